// File: src/tsl_pkg.sv
package tsl_pkg;
  // speed cap setting
  localparam logic [12:0] SPD_CAP_MAX   = 13'h1770; // 6000 r/min
  localparam logic [12:0] SPD_CAP_RST   = 13'h05DC; // 1500 r/min
  // analog speed gain, (r/min)/V
  localparam logic [11:0] GAIN_MAX      = 12'h0BB8; // 3000
  localparam logic [11:0] GAIN_RST      = 12'h0096; // 150
  localparam logic [12:0] MOTOR_MAX_RST = 13'h1770;
  // speed source select codes
  localparam logic        SRC_INTERNAL  = 1'h0;
  localparam logic        SRC_EXTERNAL  = 1'h1;
  // long press time
  localparam int          CLK_HZ        = 125000000;
  localparam int          HOLD_MS       = 1000;
  localparam int          HOLD_CYC      = CLK_HZ / 1000 * HOLD_MS;
  // register offsets (word aligned byte addresses)
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_SPDCAP    = 8'h04;
  localparam logic [7:0]  REG_GAIN      = 8'h08;
  localparam logic [7:0]  REG_MOTMAX    = 8'h0C;
  localparam logic [7:0]  REG_LIMIT     = 8'h10;
  localparam logic [7:0]  REG_OFFSET    = 8'h14;
  localparam logic [7:0]  REG_DISP      = 8'h18;
  // display codes shown on the panel
  typedef enum logic [2:0] {
    DISP_AUTO_CODE   = 3'b000, // auto_offset_code_display
    DISP_AUTO_DONE   = 3'b001, // flashing completion
    DISP_REF         = 3'b010, // steady reference offset
    DISP_MANUAL_CODE = 3'b011, // manual_offset_code_display
    DISP_MANUAL_SEL  = 3'b100,
    DISP_EDIT        = 3'b101,
    DISP_SAVED       = 3'b110
  } disp_t;
endpackage : tsl_pkg

// File: src/key_hold_timer.sv
`timescale 1ns/1ps
// counts how long a key stays pressed, flags a long hold once
module key_hold_timer #(
  parameter int HOLD = 125000000
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstSync_b,
  // key
  input  wire logic keyLevel,
  output logic      longHold
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        long_d;

  // count saturates so a held key fires only once
  always_comb begin
    cnt_d = keyLevel ? ((cnt_q == 32'(HOLD)) ? cnt_q : cnt_q + 32'h0000_0001)
                     : 32'h0000_0000;
    long_d = keyLevel && (cnt_q == 32'(HOLD - 1));
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      cnt_q    <= 32'h0000_0000;
      longHold <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      longHold <= long_d;
    end
  end
endmodule : key_hold_timer

// File: src/speed_clamp.sv
`timescale 1ns/1ps
// effective ceiling: source select, analog scaling, motor clamp
module speed_clamp (
  // settings
  input  wire logic        srcSel,
  input  wire logic [12:0] spdCap,
  input  wire logic [11:0] gain,
  input  wire logic [12:0] motorMax,
  // analog speed input
  input  wire logic [15:0] vrefMv,    // signed millivolts
  // effective ceiling
  output logic      [12:0] limit
);
  import tsl_pkg::*;
  logic [15:0] mag;
  logic [27:0] prod;
  logic [17:0] ext;
  logic [12:0] base;
  logic [12:0] pick;

  always_comb begin
    // polarity ignored: magnitude only
    mag  = vrefMv[15] ? 16'(-vrefMv) : vrefMv;
    prod = 28'(mag) * 28'(gain);
    ext  = 18'(prod / 28'h000_03E8);
    base = (spdCap > SPD_CAP_MAX) ? SPD_CAP_MAX : spdCap;
    pick = base;
    if (srcSel == SRC_EXTERNAL && ext < 18'(base)) begin
      pick = 13'(ext);
    end
    limit = (pick > motorMax) ? motorMax : pick;
  end
endmodule : speed_clamp

// File: src/torque_mode_speed_limiter.sv
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module torque_mode_speed_limiter #(
  parameter int HOLD_CYCLES = tsl_pkg::HOLD_CYC,
  parameter int KP_SHIFT    = 4
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_b,
  // wishbone slave
  input  wire logic               wbCyc,
  input  wire logic               wbStb,
  input  wire logic               wbWe,
  input  wire logic [7:0]         wbAdr,
  input  wire logic [3:0]         wbSel,
  input  wire logic [31:0]        wbDatW,
  output logic      [31:0]        wbDatR,
  output logic                    wbAck,
  // keypad, level while pressed
  input  wire logic               keyMode,
  input  wire logic               keySet,
  input  wire logic               keyUp,
  input  wire logic               keyDown,
  input  wire logic               autoZeroDone,
  // analog samples and feedback
  input  wire logic [15:0]        vrefMv,
  input  wire logic [15:0]        trefIn,
  input  wire logic [15:0]        motorSpeed,
  // outputs
  output logic      [15:0]        torqueCmd,
  output tsl_pkg::disp_t          dispCode,
  output logic      [15:0]        offsetShown
);
  import tsl_pkg::*;

  // reset synchroniser
  logic rs1_q;
  logic rstSync_b;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rs1_q     <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rs1_q     <= 1'b1;
      rstSync_b <= rs1_q;
    end
  end

  // settings
  logic        src_q,    src_d;
  logic [12:0] cap_q,    cap_d;
  logic [11:0] gain_q,   gain_d;
  logic [12:0] mmax_q,   mmax_d;
  logic [15:0] offs_q,   offs_d;
  logic [15:0] edit_q,   edit_d;
  disp_t       disp_q,   disp_d;
  logic        ack_d;
  logic [31:0] rd_d;
  logic [12:0] limit;
  logic        longSet;
  logic        setP_q, upP_q, dnP_q, modeP_q;
  logic        setEdge, upEdge, dnEdge, modeEdge;
  logic [15:0] tcmd_d;

  key_hold_timer #(.HOLD(HOLD_CYCLES)) uHold (
    .mclk      (mclk),
    .rstSync_b (rstSync_b),
    .keyLevel  (keySet),
    .longHold  (longSet)
  );

  speed_clamp uClamp (
    .srcSel   (src_q),
    .spdCap   (cap_q),
    .gain     (gain_q),
    .motorMax (mmax_q),
    .vrefMv   (vrefMv),
    .limit    (limit)
  );

  // short set presses act on release so a long hold is not also a short press; up, down and mode act on press
  assign setEdge  = setP_q && !keySet;
  assign upEdge   = keyUp && !upP_q;
  assign dnEdge   = keyDown && !dnP_q;
  assign modeEdge = keyMode && !modeP_q;

  // long hold seen during this press, suppresses the release action except in DISP_REF
  logic wasLong_q, wasLong_d;

  // keypad menu
  always_comb begin
    disp_d    = disp_q;
    edit_d    = edit_q;
    offs_d    = offs_q;
    wasLong_d = keySet ? (wasLong_q | longSet) : 1'b0;
    unique case (disp_q)
      DISP_AUTO_CODE: begin
        if (setEdge && !wasLong_q) disp_d = DISP_AUTO_DONE;
        else if (upEdge || dnEdge) disp_d = DISP_MANUAL_CODE;
      end
      DISP_AUTO_DONE: begin
        if (autoZeroDone) disp_d = DISP_REF;
      end
      DISP_REF: begin
        if (setEdge) disp_d = DISP_AUTO_CODE;
      end
      DISP_MANUAL_CODE: begin
        if (setEdge && !wasLong_q) disp_d = DISP_MANUAL_SEL;
        else if (upEdge || dnEdge) disp_d = DISP_AUTO_CODE;
      end
      DISP_MANUAL_SEL: begin
        if (longSet) begin
          disp_d = DISP_EDIT;
          edit_d = 16'h0000;
        end
      end
      DISP_EDIT: begin
        if (upEdge) edit_d = edit_q + 16'h0001;
        else if (dnEdge) edit_d = edit_q - 16'h0001;
        if (longSet && wasLong_q == 1'b0) begin
          offs_d = edit_q;
          disp_d = DISP_SAVED;
        end
      end
      DISP_SAVED: begin
        if (setEdge && !wasLong_q) disp_d = DISP_MANUAL_CODE;
      end
      default: disp_d = DISP_AUTO_CODE;
    endcase
    if (modeEdge) disp_d = DISP_AUTO_CODE;
  end

  // torque command with offset and overspeed pullback
  logic signed [17:0] sum;
  logic signed [17:0] excess;
  logic signed [17:0] corr;
  always_comb begin
    sum    = 18'($signed(trefIn)) + 18'($signed(offs_q));
    excess = 18'($signed(motorSpeed)) - 18'($signed({3'b000, limit}));
    corr   = 18'sh0_0000;
    if (excess > 18'sh0_0000) begin
      corr = excess >>> KP_SHIFT;
    end else if (excess + 18'($signed({3'b000, limit}))
                 < -18'($signed({3'b000, limit}))) begin
      // negative overspeed mirrors the positive case
      corr = (excess + 18'($signed({4'b0000, limit, 1'b0}))) >>> KP_SHIFT;
    end
    sum = sum - corr;
    if (sum > 18'sh0_7FFF) tcmd_d = 16'h7FFF;
    else if (sum < -18'sh0_8000) tcmd_d = 16'h8000;
    else tcmd_d = sum[15:0];
  end

  // wishbone register file, single registered ack, one wait state
  always_comb begin
    src_d  = src_q;
    cap_d  = cap_q;
    gain_d = gain_q;
    mmax_d = mmax_q;
    ack_d  = wbCyc && wbStb && !wbAck;
    rd_d   = 32'h0000_0000;
    if (ack_d && wbWe && wbSel[0]) begin
      unique case (wbAdr)
        REG_CTRL:   src_d = wbDatW[0];
        REG_SPDCAP: begin
          if (wbSel[1] && wbDatW[12:0] <= SPD_CAP_MAX)
            cap_d = wbDatW[12:0];
        end
        REG_GAIN: begin
          if (wbSel[1] && wbDatW[11:0] <= GAIN_MAX)
            gain_d = wbDatW[11:0];
        end
        REG_MOTMAX: if (wbSel[1]) mmax_d = wbDatW[12:0];
        default: ;
      endcase
    end
    unique case (wbAdr)
      REG_CTRL:   rd_d = {31'h0000_0000, src_q};
      REG_SPDCAP: rd_d = {19'h0_0000, cap_q};
      REG_GAIN:   rd_d = {20'h0_0000, gain_q};
      REG_MOTMAX: rd_d = {19'h0_0000, mmax_q};
      REG_LIMIT:  rd_d = {19'h0_0000, limit};
      REG_OFFSET: rd_d = {16'h0000, offs_q};
      REG_DISP:   rd_d = {29'h0000_0000, disp_q};
      default:    rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      src_q       <= SRC_INTERNAL;
      cap_q       <= SPD_CAP_RST;
      gain_q      <= GAIN_RST;
      mmax_q      <= MOTOR_MAX_RST;
      offs_q      <= 16'h0000;
      edit_q      <= 16'h0000;
      disp_q      <= DISP_AUTO_CODE;
      wasLong_q   <= 1'b0;
      setP_q      <= 1'b0;
      upP_q       <= 1'b0;
      dnP_q       <= 1'b0;
      modeP_q     <= 1'b0;
      wbAck       <= 1'b0;
      wbDatR      <= 32'h0000_0000;
      torqueCmd   <= 16'h0000;
      dispCode    <= DISP_AUTO_CODE;
      offsetShown <= 16'h0000;
    end else begin
      src_q       <= src_d;
      cap_q       <= cap_d;
      gain_q      <= gain_d;
      mmax_q      <= mmax_d;
      offs_q      <= offs_d;
      edit_q      <= edit_d;
      disp_q      <= disp_d;
      wasLong_q   <= wasLong_d;
      setP_q      <= keySet;
      upP_q       <= keyUp;
      dnP_q       <= keyDown;
      modeP_q     <= keyMode;
      wbAck       <= ack_d;
      wbDatR      <= ack_d ? rd_d : 32'h0000_0000;
      torqueCmd   <= tcmd_d;
      dispCode    <= disp_d;
      offsetShown <= (disp_d == DISP_EDIT) ? edit_d : offs_d;
    end
  end

  // checks, mode key overrides so five antecedents exclude it
  a_done_to_ref: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    disp_q == DISP_AUTO_DONE && autoZeroDone && !modeEdge
    |=> disp_q == DISP_REF)
    else $error("done did not go to ref");
  a_ref_to_code: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    disp_q == DISP_REF && setEdge |=> disp_q == DISP_AUTO_CODE)
    else $error("set from ref did not return");
  a_edit_zero: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    disp_q == DISP_MANUAL_SEL && longSet && !modeEdge
    |=> disp_q == DISP_EDIT && edit_q == 16'h0000)
    else $error("edit entry not zero");
  a_edit_up: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    disp_q == DISP_EDIT && upEdge && !modeEdge
    |=> edit_q == $past(edit_q) + 16'h0001)
    else $error("up did not step");
  a_edit_down: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    disp_q == DISP_EDIT && dnEdge && !upEdge && !modeEdge
    |=> edit_q == $past(edit_q) - 16'h0001)
    else $error("down did not step");
  a_offs_stable: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    !(disp_q == DISP_EDIT && longSet) |=> $stable(offs_q))
    else $error("offset changed without save");
  a_offs_save: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    disp_q == DISP_EDIT && longSet |=> offs_q == $past(edit_q))
    else $error("offset not saved on long hold");
  a_saved_code: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    disp_q == DISP_SAVED && setEdge && !wasLong_q && !modeEdge
    |=> disp_q == DISP_MANUAL_CODE)
    else $error("saved set did not return");
  a_limit_motor: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    limit <= mmax_q && limit <= cap_q)
    else $error("limit above ceiling");
  a_limit_int: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    src_q == SRC_INTERNAL |-> limit == ((cap_q > mmax_q) ? mmax_q : cap_q))
    else $error("internal limit wrong");
  a_cap_range: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    cap_q <= SPD_CAP_MAX)
    else $error("cap out of range");
  a_ack_drop: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    wbAck |=> !wbAck)
    else $error("ack held two cycles");
  a_mode_home: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    modeEdge |=> disp_q == DISP_AUTO_CODE)
    else $error("mode key did not return home");
  c_edit_save: cover property (@(posedge mclk) disable iff (!rstSync_b)
    disp_q == DISP_EDIT ##1 disp_q == DISP_SAVED);
  c_auto_done: cover property (@(posedge mclk) disable iff (!rstSync_b)
    disp_q == DISP_AUTO_DONE ##1 disp_q == DISP_REF);
  c_ext_limit: cover property (@(posedge mclk) disable iff (!rstSync_b)
    src_q == SRC_EXTERNAL && limit < cap_q);
  c_saved_back: cover property (@(posedge mclk) disable iff (!rstSync_b)
    disp_q == DISP_SAVED ##1 disp_q == DISP_MANUAL_CODE);
endmodule : torque_mode_speed_limiter

// File: verif/panel_host_model.sv
`timescale 1ns/1ps
// operator keypad and host analog outputs facing the limiter
module panel_host_model #(
  parameter int HOLD = 20
) (
  // clock
  input  wire logic        mclk,
  // keypad levels and auto zero flag
  output logic             keyMode,
  output logic             keySet,
  output logic             keyUp,
  output logic             keyDown,
  output logic             autoZeroDone,
  // analog samples
  output logic      [15:0] vrefMv,
  output logic      [15:0] trefIn
);
  logic [3:0] keys = 4'h0;

  // key index 0 mode, 1 set, 2 up, 3 down
  assign {keyDown, keyUp, keySet, keyMode} = keys;

  // idle panel and zero analog at time zero
  initial begin
    autoZeroDone = 1'b0;
    vrefMv       = 16'h0000;
    trefIn       = 16'h0000;
  end

  // gap after release so the release action lands before the next key
  task press(input int k, input int n);
    @(posedge mclk);
    keys[k] <= 1'b1;
    repeat (n) @(posedge mclk);
    keys[k] <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : press

  // margin beyond the hold time, a real operator is never exact
  task longSet();
    press(1, HOLD + 4);
  endtask : longSet

  // finished auto zero run, one cycle
  task zeroDone();
    @(posedge mclk);
    autoZeroDone <= 1'b1;
    @(posedge mclk);
    autoZeroDone <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : zeroDone

  task setAnalog(input logic [15:0] v, input logic [15:0] t);
    @(posedge mclk);
    vrefMv <= v;
    trefIn <= t;
  endtask : setAnalog
endmodule : panel_host_model

// File: verif/torque_mode_speed_limiter_test.sv
`timescale 1ns/1ps
module torque_mode_speed_limiter_test;
  import tsl_pkg::*;
  logic mclk = 1'b0, rst_b = 1'b0, wbCyc = 1'b0, wbStb = 1'b0;
  logic wbWe = 1'b0, wbAck;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'hF;
  logic [31:0] wbDatW = 32'h0000_0000, wbDatR, rdData;
  logic keyMode, keySet, keyUp, keyDown, autoZeroDone;
  logic [15:0] vrefMv, trefIn, torqueCmd, offsetShown;
  logic [15:0] motorSpeed = 16'h0000;
  disp_t       dispCode;
  int fails = 0, samplesChecked = 0, cycles = 0;

  torque_mode_speed_limiter #(.HOLD_CYCLES(20), .KP_SHIFT(4)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
    .wbDatR(wbDatR), .wbAck(wbAck), .keyMode(keyMode),
    .keySet(keySet), .keyUp(keyUp), .keyDown(keyDown),
    .autoZeroDone(autoZeroDone), .vrefMv(vrefMv), .trefIn(trefIn),
    .motorSpeed(motorSpeed), .torqueCmd(torqueCmd),
    .dispCode(dispCode), .offsetShown(offsetShown));

  panel_host_model #(.HOLD(20)) u_panel (
    .mclk(mclk), .keyMode(keyMode), .keySet(keySet), .keyUp(keyUp),
    .keyDown(keyDown), .autoZeroDone(autoZeroDone),
    .vrefMv(vrefMv), .trefIn(trefIn));

  // 8 ns period
  initial begin
    forever #4 mclk = ~mclk;
  end

  task end_sim();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  // whole run needs about 300 cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails = fails + 1;
      end_sim();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samplesChecked = samplesChecked + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // request stands until ack is sampled high at a rising edge
  task wbCycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= w;
    wbAdr  <= a;
    wbDatW <= d;
    @(posedge mclk);
    while (wbAck !== 1'b1) @(posedge mclk);
    rdData = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wbCycle

  task wr(input logic [7:0] a, input logic [15:0] d);
    wbCycle(1'b1, a, {16'h0000, d});
  endtask : wr

  task rdChk(input logic [7:0] a, input logic [15:0] e);
    wbCycle(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), {16'h0000, e}, rdData);
  endtask : rdChk

  task dispChk(input disp_t e);
    repeat (2) @(posedge mclk);
    chk("dispCode", {29'h0, e}, {29'h0, dispCode});
  endtask : dispChk

  task torqChk(input logic [15:0] s, input logic [15:0] e);
    @(posedge mclk);
    motorSpeed <= s;
    repeat (3) @(posedge mclk);
    chk("torqueCmd", {16'h0000, e}, {16'h0000, torqueCmd});
  endtask : torqChk

  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    // reset values and an unmapped place
    rdChk(REG_CTRL, 16'h0000);
    rdChk(REG_SPDCAP, 16'h05DC);
    rdChk(REG_GAIN, 16'h0096);
    rdChk(REG_MOTMAX, 16'h1770);
    rdChk(REG_LIMIT, 16'h05DC);
    rdChk(8'h1C, 16'h0000);
    // cap out of range refused, in range live
    wr(REG_SPDCAP, 16'h1771);
    rdChk(REG_SPDCAP, 16'h05DC);
    wr(REG_SPDCAP, 16'h0064);
    rdChk(REG_LIMIT, 16'h0064);
    wr(REG_SPDCAP, 16'h1770);
    wr(REG_MOTMAX, 16'h0BB8);
    rdChk(REG_LIMIT, 16'h0BB8);
    // external, -6 V at gain 150 gives 900
    u_panel.setAnalog(16'hE890, 16'h0064);
    wr(REG_CTRL, 16'h0001);
    rdChk(REG_LIMIT, 16'h0384);
    wr(REG_GAIN, 16'h0BB9);
    rdChk(REG_GAIN, 16'h0096);
    wr(REG_SPDCAP, 16'h01F4);
    rdChk(REG_LIMIT, 16'h01F4);
    // excess 160 over 500 gives 10 of correction, both directions
    torqChk(16'h0294, 16'h005A);
    torqChk(16'hFD6C, 16'h006E);
    torqChk(16'h0000, 16'h0064);
    // auto offset panel walk
    u_panel.press(0, 2);
    dispChk(DISP_AUTO_CODE);
    u_panel.press(1, 2);
    dispChk(DISP_AUTO_DONE);
    u_panel.zeroDone();
    dispChk(DISP_REF);
    u_panel.press(1, 2);
    dispChk(DISP_AUTO_CODE);
    // manual offset entry
    u_panel.press(2, 2);
    dispChk(DISP_MANUAL_CODE);
    u_panel.press(1, 2);
    dispChk(DISP_MANUAL_SEL);
    u_panel.press(1, 10);
    dispChk(DISP_MANUAL_SEL);
    u_panel.longSet();
    dispChk(DISP_EDIT);
    chk("offsetShown", 32'h0000_0000, {16'h0000, offsetShown});
    for (int i = 0; i < 3; i++) u_panel.press(2, 2);
    u_panel.press(3, 2);
    dispChk(DISP_EDIT);
    chk("offsetShown", 32'h0000_0002, {16'h0000, offsetShown});
    u_panel.press(1, 10);
    rdChk(REG_OFFSET, 16'h0000);
    u_panel.longSet();
    dispChk(DISP_SAVED);
    rdChk(REG_DISP, 16'h0006);
    rdChk(REG_OFFSET, 16'h0002);
    torqChk(16'h0000, 16'h0066);
    u_panel.press(1, 2);
    dispChk(DISP_MANUAL_CODE);
    // down in the manual code goes back to the auto code
    u_panel.press(3, 2);
    dispChk(DISP_AUTO_CODE);
    end_sim();
  end
endmodule : torque_mode_speed_limiter_test
